// ===== hw/tone_gen_regs.svh
// Register offsets, field positions and timing constants of the tone generator.
`ifndef TONE_GEN_REGS_SVH
`define TONE_GEN_REGS_SVH
`define TONE_CTRL_ADDR        8'h00
`define PORT_MODE_ADDR        8'h01
`define TONE_CMP_MSB          5
`define TONE_CMP_LSB          0
`define TONE_SEL_MSB          7
`define TONE_SEL_LSB          6
`define TONE_PIN_SEL_BIT      4
`define PORT_MODE_RESET       8'h00
`define TONE_CTRL_RESET       8'h00
`define MAIN_CLK_HZ           4000000
`define SYS_CLK_HZ            100000000
`define TONE_DIV_BASE         8
`define SUB_CLK_EXTRA_DIV     128
`define TONE_DIV_BASE_CYC     ((`SYS_CLK_HZ / `MAIN_CLK_HZ) * `TONE_DIV_BASE)
`endif

// ===== hw/tone_gen_pkg.sv
// Types shared by the tone generator.
package tone_gen_pkg;
  typedef struct packed {
    logic [1:0] prescale_sel;
    logic [5:0] compare;
  } tone_ctrl_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
endpackage

// ===== hw/buzzer_square_wave_gen.sv
// Programmable square-wave tone generator with a plain register port.
// Operation
// - Control write clears and restarts tone counter.
// - Counter increments each tick until compare matches.
// - Match clears counter, toggles output: 50% duty.
// - Tone reaches pin only when select bit set.
// - Control register is write-only.
// - Upper two bits select prescaler tap.
// - Frequency = osc / (2 * ratio * (cmp+1)).
// - Codes 00..11 give ratios 8,16,32,64.
// - Sub-clock source divides frequency by 128.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "tone_gen_regs.svh"
module buzzer_square_wave_gen #(
  parameter int BASE_CYC = `TONE_DIV_BASE_CYC,
  parameter int SUB_DIV  = `SUB_CLK_EXTRA_DIV
) (
  // Clock and reset.
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  // Register port.
  input  wire tone_gen_pkg::reg_req_t req_i,
  output logic [7:0]                  rdata_o,
  // Clock source and port pin.
  input  wire logic                   sub_clk_sel_i,
  input  wire logic                   port_data_i,
  output logic                        tone_port_pin_o,
  output logic                        tone_o
);
  // Refuse divider settings that the prescaler counters cannot serve.
  if (BASE_CYC < 1 || SUB_DIV < 1) begin : g_bad_divider
    $error("Divider parameters must be at least one.");
  end

  logic rst_meta_reg;
  logic rst_sync_n;
  logic sub_meta_reg;
  logic sub_sel_reg;
  logic port_meta_reg;
  logic port_sync_reg;
  tone_gen_pkg::tone_ctrl_t tone_divider_control;
  logic [7:0]  port_mode_reg;
  logic [31:0] pre_cnt_reg;
  logic [31:0] sub_cnt_reg;
  logic [5:0]  tone_cnt_reg;
  logic        tone_reg;
  logic        base_tick;
  logic        tick;
  logic        ctrl_wr;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  // Pins from outside the clock domain pass two flip-flops.
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sub_meta_reg  <= 1'b0;
      sub_sel_reg   <= 1'b0;
      port_meta_reg <= 1'b0;
      port_sync_reg <= 1'b0;
    end else begin
      sub_meta_reg  <= sub_clk_sel_i;
      sub_sel_reg   <= sub_meta_reg;
      port_meta_reg <= port_data_i;
      port_sync_reg <= port_meta_reg;
    end
  end

  assign ctrl_wr = req_i.wr && (req_i.addr == `TONE_CTRL_ADDR);

  // The compare field is cleared here for determinism; software still sets it.
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tone_divider_control <= `TONE_CTRL_RESET;
      port_mode_reg        <= `PORT_MODE_RESET;
    end else if (ctrl_wr) begin
      tone_divider_control <= req_i.wdata;
    end else if (req_i.wr && (req_i.addr == `PORT_MODE_ADDR)) begin
      port_mode_reg <= req_i.wdata;
    end
  end

  // The control register is write-only and reads as zero.
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd && (req_i.addr == `PORT_MODE_ADDR)) begin
      rdata_o <= port_mode_reg;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Base prescaler: one tick per ratio-8 period of the main clock, scaled
  // by 128 when the slow source is selected.
  assign base_tick = (pre_cnt_reg == 32'(BASE_CYC - 1)) &&
                     (!sub_sel_reg || sub_cnt_reg == 32'(SUB_DIV - 1));

  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pre_cnt_reg <= 32'h0;
      sub_cnt_reg <= 32'h0;
    end else if (pre_cnt_reg == 32'(BASE_CYC - 1)) begin
      pre_cnt_reg <= 32'h0;
      if (!sub_sel_reg || sub_cnt_reg == 32'(SUB_DIV - 1)) begin
        sub_cnt_reg <= 32'h0;
      end else begin
        sub_cnt_reg <= sub_cnt_reg + 32'h1;
      end
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 32'h1;
    end
  end

  // Tap select: ratio 8 << code, via a free-running 3-bit tap counter.
  logic [2:0] tap_cnt_reg;
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tap_cnt_reg <= 3'h0;
    end else if (base_tick) begin
      tap_cnt_reg <= tap_cnt_reg + 3'h1;
    end
  end

  always_comb begin
    case (tone_divider_control.prescale_sel)
      2'h0:    tick = base_tick;
      2'h1:    tick = base_tick && (tap_cnt_reg[0] == 1'b1);
      2'h2:    tick = base_tick && (tap_cnt_reg[1:0] == 2'h3);
      default: tick = base_tick && (tap_cnt_reg == 3'h7);
    endcase
  end

  // Base ticks seen since the last tone tick. The spacing is only judged once
  // a tick has passed under the present code: the tap counter runs free, so
  // the first tick after a code change may come early.
  logic [2:0] tap_gap_reg;
  logic       tap_steady_reg;
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tap_gap_reg <= 3'h0;
    end else if (tick) begin
      tap_gap_reg <= 3'h0;
    end else if (base_tick) begin
      tap_gap_reg <= tap_gap_reg + 3'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tap_steady_reg <= 1'b0;
    end else if (ctrl_wr && req_i.wdata[`TONE_SEL_MSB:`TONE_SEL_LSB] != tone_divider_control.prescale_sel) begin
      tap_steady_reg <= 1'b0;
    end else if (tick) begin
      tap_steady_reg <= 1'b1;
    end
  end

  // A control write wins over a tick in the same cycle, so the counter always restarts from zero; the prescaler is not restarted.
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tone_cnt_reg <= 6'h00;
      tone_reg     <= 1'b0;
    end else if (ctrl_wr) begin
      tone_cnt_reg <= 6'h00;
    end else if (tick) begin
      if (tone_cnt_reg == tone_divider_control.compare) begin
        tone_cnt_reg <= 6'h00;
        tone_reg     <= ~tone_reg;
      end else begin
        tone_cnt_reg <= tone_cnt_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tone_o          <= 1'b0;
      tone_port_pin_o <= 1'b0;
    end else begin
      // Both outputs are registered, so while the select bit routes the tone, the pin and tone_o change in the same cycle, one cycle after tone_reg.
      tone_o          <= tone_reg;
      tone_port_pin_o <= port_mode_reg[`TONE_PIN_SEL_BIT] ? tone_reg : port_sync_reg;
    end
  end

  // Checks run on the synchronised reset so that they stay quiet while the
  // release ripples through its two flip-flops.
  a_write_clears: assert property (@(posedge core_clk_i) disable iff (!rst_sync_n)
    ctrl_wr |=> tone_cnt_reg == 6'h00) else $error("Counter not cleared by write.");
  a_count_bound: assert property (@(posedge core_clk_i) disable iff (!rst_sync_n)
    (tick && !ctrl_wr && tone_cnt_reg != tone_divider_control.compare) |=>
    tone_cnt_reg == $past(tone_cnt_reg) + 6'h01) else $error("Counter failed to step.");
  a_match_toggle: assert property (@(posedge core_clk_i) disable iff (!rst_sync_n)
    (tick && !ctrl_wr && tone_cnt_reg == tone_divider_control.compare) |=>
    tone_reg != $past(tone_reg)) else $error("Tone did not toggle on match.");
  a_hold_level: assert property (@(posedge core_clk_i) disable iff (!rst_sync_n)
    !tick |=> $stable(tone_reg)) else $error("Tone changed without a tick.");
  a_pin_route: assert property (@(posedge core_clk_i) disable iff (!rst_sync_n)
    port_mode_reg[`TONE_PIN_SEL_BIT] && $stable(port_mode_reg) |=>
    tone_port_pin_o == $past(tone_reg)) else $error("Pin not carrying tone.");
  a_pin_port: assert property (@(posedge core_clk_i) disable iff (!rst_sync_n)
    !port_mode_reg[`TONE_PIN_SEL_BIT] && $stable(port_mode_reg) |=>
    tone_port_pin_o == $past(port_sync_reg)) else $error("Pin not carrying port data.");
  a_ctrl_wo: assert property (@(posedge core_clk_i) disable iff (!rst_sync_n)
    req_i.rd && req_i.addr == `TONE_CTRL_ADDR |=> rdata_o == 8'h00) else $error("Control readable.");
  a_tap_fast: assert property (@(posedge core_clk_i) disable iff (!rst_sync_n)
    tone_divider_control.prescale_sel == 2'h0 |-> tick == base_tick) else $error("Tap 00 wrong.");
  a_tap_spacing: assert property (@(posedge core_clk_i) disable iff (!rst_sync_n)
    tick && tap_steady_reg |-> tap_gap_reg == 3'((4'h1 << tone_divider_control.prescale_sel) - 4'h1))
    else $error("Tap spacing wrong.");
  a_sub_gate: assert property (@(posedge core_clk_i) disable iff (!rst_sync_n)
    sub_sel_reg && base_tick |-> sub_cnt_reg == 32'(SUB_DIV - 1)) else $error("Sub divide wrong.");
endmodule

// ===== sim/tone_listener.sv
// Behavioural buzzer on the tone pin that times each high and low phase in clock cycles.
`timescale 1ns/1ps
module tone_listener (
  input  wire logic core_clk_i,
  input  wire logic pin_i,
  output int        hi_o,
  output int        lo_o,
  output int        edges_o
);
  logic pin_reg = 1'b0;
  int   run_reg = 0;
  initial hi_o = 0;
  initial lo_o = 0;
  initial edges_o = 0;
  // A piezo only reacts to edges, so only complete phases are reported.
  always @(posedge core_clk_i) begin
    pin_reg <= pin_i;
    if (pin_i !== pin_reg) begin
      if (pin_reg) hi_o <= run_reg + 1;
      else lo_o <= run_reg + 1;
      run_reg <= 0;
      edges_o <= edges_o + 1;
    end else begin
      run_reg <= run_reg + 1;
    end
  end
endmodule

// ===== sim/buzzer_square_wave_gen_tb_top.sv
// Self-checking bench of the tone generator.
`timescale 1ns/1ps
`include "tone_gen_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %0d seen %0d", nm, e, g); end end
module buzzer_square_wave_gen_tb_top;
  localparam int BASE = 2;
  localparam int SUBD = 2;
  logic                   core_clk_i = 1'b0;
  logic                   rst_n_i = 1'b0;
  tone_gen_pkg::reg_req_t req_i = '0;
  logic [7:0]             rdata_o;
  logic                   sub_clk_sel_i = 1'b0;
  logic                   port_data_i = 1'b0;
  logic                   tone_port_pin_o;
  logic                   tone_o;
  int                     hi, lo, edges, n;
  int                     failures = 0;
  int                     total_checks = 0;
  initial forever #5 core_clk_i = ~core_clk_i;
  buzzer_square_wave_gen #(.BASE_CYC(BASE), .SUB_DIV(SUBD)) i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .req_i(req_i), .rdata_o(rdata_o), .sub_clk_sel_i(sub_clk_sel_i), .port_data_i(port_data_i),
    .tone_port_pin_o(tone_port_pin_o), .tone_o(tone_o));
  tone_listener i_buzzer (.core_clk_i(core_clk_i), .pin_i(tone_port_pin_o), .hi_o(hi), .lo_o(lo), .edges_o(edges));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    req_i <= '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    req_i <= '0;
    #1;
    `CHK("rdata", e, rdata_o)
    @(posedge core_clk_i);
  endtask
  // Only whole phases after the restart are judged, so the sync lag of the source select cannot blur them.
  task automatic measure(input logic [7:0] c, input logic s);
    int h;
    h = (BASE << c[7:6]) * (c[5:0] + 1) * (s ? SUBD : 1);
    sub_clk_sel_i <= s;
    wr(`TONE_CTRL_ADDR, c);
    n = edges;
    repeat (h * 6 + 100) if (edges < n + 4) @(posedge core_clk_i);
    `CHK("high_phase", h, hi)
    `CHK("low_phase", h, lo)
    `CHK("tone_raw", tone_port_pin_o, tone_o)
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    `CHK("tone_rst", 1'b0, tone_o)
    `CHK("pin_rst", 1'b0, tone_port_pin_o)
    wr(`TONE_CTRL_ADDR, 8'h00);
    rd_chk(`TONE_CTRL_ADDR, 8'h00);
    rd_chk(8'hff, 8'h00);
    port_data_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    `CHK("pin_port", 1'b1, tone_port_pin_o)
    port_data_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    `CHK("pin_port", 1'b0, tone_port_pin_o)
    wr(`PORT_MODE_ADDR, 8'h10);
    wr(8'h02, 8'hff);
    rd_chk(`PORT_MODE_ADDR, 8'h10);
    for (int s = 0; s < 4; s++) measure({s[1:0], 6'(s * 21)}, 1'b0);
    measure(8'h41, 1'b1);
    measure(8'h45, 1'b0);
    rd_chk(`TONE_CTRL_ADDR, 8'h00);
    n = edges;
    repeat (60) if (edges == n) @(posedge core_clk_i);
    repeat (10) @(posedge core_clk_i);
    wr(`TONE_CTRL_ADDR, 8'h45);
    n = 0;
    while (tone_port_pin_o === i_buzzer.pin_reg && n < 100) begin
      @(posedge core_clk_i);
      n++;
    end
    `CHK("restart_gap", 1'b1, (n >= 19 && n <= 30))
    tally_and_finish();
  end
  initial begin
    repeat (50000) @(posedge core_clk_i);
    failures++;
    tally_and_finish();
  end
endmodule
